// file: sstat_bank.sv
/*
 * sstat_bank: read-only spindle status bank seen over AXI4-Lite.
 * Assumes status sources are synchronous to aclk; a one-cycle scan
 * pulse from the controller marks when all inputs are coherent.
 */
`default_nettype none

// Behaviour
// - bit0 alarm flag follows spindle alarm
// - bit1 set below stop-detection frequency
// - bit2 set at or below preset frequency
// - bit3 set when frequency within preset range
// - bit4 set when load exceeds level
// - bit6 set while torque limit applied
// - bit7 set when orientation complete
// - second spindle byte has identical layout
// - enable flag set when velocity command nonzero
// - fluctuation alarm while speed out of range
// - M and S strobes when codes effective
// - surface speed flag while control active
// - speed sync flag while sync active
// - phase sync flag while phase sync active
// - sync fault flag on sync control fault
// - load meter 16 bits, 0 to 32767
// - motor frequency 16 bits, 0 to 16383
// - alarm number as 8-bit byte
// - speed command value on output bits
// - rigid tap flag while tapping
module sstat_bank
   import sstat_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // controller scan strobe
   input wire logic scan_tick,
   // per-spindle status sources, index 0 first spindle, 1 second
   input wire logic [1:0] spindle_alarm,
   input wire logic [1:0] freq_below_stop,
   input wire logic [1:0] freq_not_above_preset,
   input wire logic [1:0] freq_in_range,
   input wire logic [1:0] load_over_level,
   input wire logic [1:0] torque_limit_on,
   input wire logic [1:0] orient_in_range,
   input wire logic [1:0] orient_commanded,
   // controller sources
   input wire logic [15:0] speed_command_in,
   input wire logic m_code_effective,
   input wire logic s_code_effective,
   input wire logic speed_out_of_range,
   input wire logic css_control_on,
   input wire logic speed_sync_on,
   input wire logic phase_sync_on,
   input wire logic sync_fault,
   input wire logic rigid_tap_on,
   input wire logic [31:0] s_code_in,
   input wire logic [15:0] load_meter_in,
   input wire logic [15:0] motor_freq_in,
   input wire logic [7:0] alarm_number_in,
   // status outputs to the machine-side controller
   output logic [7:0] first_spindle_status_flags,
   output logic [7:0] second_spindle_status_flags,
   output logic [15:0] speed_command_output,
   output logic m_code_strobe,
   output logic s_code_strobe,
   output logic nonzero_velocity_flag,
   output logic speed_fluctuation_alarm,
   output logic constant_surface_speed_active,
   output logic speed_sync_active,
   output logic phase_sync_active,
   output logic sync_fault_flag,
   output logic rigid_tap_active,
   output logic [31:0] spindle_function_code,
   output logic [15:0] load_meter_word,
   output logic [15:0] motor_frequency_word,
   output logic [7:0] alarm_number_byte,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // builds one spindle status byte from its sources
   function automatic logic [7:0] pack_flags(input logic alm, input logic halt,
                                             input logic below, input logic match,
                                             input logic load, input logic torque,
                                             input logic orient);
      logic [7:0] f;
      f = 8'h00;
      f[SSTAT_ALM_BIT] = alm;
      f[SSTAT_HALT_BIT] = halt;
      f[SSTAT_BELOW_BIT] = below;
      f[SSTAT_MATCH_BIT] = match;
      f[SSTAT_LOAD_BIT] = load;
      f[SSTAT_SPARE_BIT] = 1'b0;
      f[SSTAT_TORQUE_BIT] = torque;
      f[SSTAT_ORIENT_BIT] = orient;
      return f;
   endfunction

   // saturating clamp so values never leave their documented range
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] max);
      return (v > max) ? max : v;
   endfunction

   logic [7:0] flags_d [2];
   logic [15:0] misc_q;

   // per-spindle flag bytes share one layout
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         flags_d[i] = pack_flags(spindle_alarm[i], freq_below_stop[i],
                                 freq_not_above_preset[i], freq_in_range[i],
                                 load_over_level[i], torque_limit_on[i],
                                 orient_commanded[i] & orient_in_range[i]);
      end
   end

   // snapshot everything on the scan pulse so multi-byte values stay coherent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_spindle_status_flags <= 8'h00;
         second_spindle_status_flags <= 8'h00;
         speed_command_output <= 16'h0000;
         nonzero_velocity_flag <= 1'b0;
         spindle_function_code <= SSTAT_ZERO_WORD;
         load_meter_word <= 16'h0000;
         motor_frequency_word <= 16'h0000;
         alarm_number_byte <= 8'h00;
      end else if (scan_tick) begin
         first_spindle_status_flags <= flags_d[0];
         second_spindle_status_flags <= flags_d[1];
         speed_command_output <= speed_command_in;
         nonzero_velocity_flag <= (speed_command_in != 16'h0000);
         spindle_function_code <= s_code_in;
         load_meter_word <= clamp16(load_meter_in, SSTAT_LOAD_MAX);
         motor_frequency_word <= clamp16(motor_freq_in, SSTAT_FREQ_MAX);
         alarm_number_byte <= alarm_number_in;
      end
   end

   // mode and strobe flags, also sampled on the scan
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         m_code_strobe <= 1'b0;
         s_code_strobe <= 1'b0;
         speed_fluctuation_alarm <= 1'b0;
         constant_surface_speed_active <= 1'b0;
         speed_sync_active <= 1'b0;
         phase_sync_active <= 1'b0;
         sync_fault_flag <= 1'b0;
         rigid_tap_active <= 1'b0;
      end else if (scan_tick) begin
         m_code_strobe <= m_code_effective;
         s_code_strobe <= s_code_effective;
         speed_fluctuation_alarm <= speed_out_of_range;
         constant_surface_speed_active <= css_control_on;
         speed_sync_active <= speed_sync_on;
         phase_sync_active <= phase_sync_on;
         sync_fault_flag <= sync_fault;
         rigid_tap_active <= rigid_tap_on;
      end
   end

   // misc word gathered from the registered flags
   always_comb begin
      misc_q = 16'h0000;
      misc_q[SSTAT_MSTB_BIT] = m_code_strobe;
      misc_q[SSTAT_SSTB_BIT] = s_code_strobe;
      misc_q[SSTAT_NZV_BIT] = nonzero_velocity_flag;
      misc_q[SSTAT_FLUCT_BIT] = speed_fluctuation_alarm;
      misc_q[SSTAT_CSS_BIT] = constant_surface_speed_active;
      misc_q[SSTAT_SPSY_BIT] = speed_sync_active;
      misc_q[SSTAT_PHSY_BIT] = phase_sync_active;
      misc_q[SSTAT_SYFLT_BIT] = sync_fault_flag;
      misc_q[SSTAT_RIGID_TAP_ACTIVE_BIT] = rigid_tap_active;
   end

   // write path: address and data taken in either order, then SLVERR at or below SSTAT_ALARM_OFS, DECERR above
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] aw_addr_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SSTAT_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            // every register is read-only, so writes change nothing
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q <= SSTAT_ALARM_OFS) ? SSTAT_RESP_SLVERR
                                                          : SSTAT_RESP_DECERR;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read path: one read in flight, answer the cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= SSTAT_ZERO_WORD;
         s_axi_rresp <= SSTAT_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SSTAT_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
               SSTAT_FLAGS1_OFS: s_axi_rdata <= {24'h000000, first_spindle_status_flags};
               SSTAT_FLAGS2_OFS: s_axi_rdata <= {24'h000000, second_spindle_status_flags};
               SSTAT_SPEED_OFS: s_axi_rdata <= {16'h0000, speed_command_output};
               SSTAT_MISC_OFS: s_axi_rdata <= {16'h0000, misc_q};
               SSTAT_SCODE_OFS: s_axi_rdata <= spindle_function_code;
               SSTAT_LOAD_OFS: s_axi_rdata <= {16'h0000, load_meter_word};
               SSTAT_FREQ_OFS: s_axi_rdata <= {16'h0000, motor_frequency_word};
               SSTAT_ALARM_OFS: s_axi_rdata <= {24'h000000, alarm_number_byte};
               default: begin
                  s_axi_rdata <= SSTAT_ZERO_WORD;
                  s_axi_rresp <= SSTAT_RESP_DECERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// file: sstat_pkg.sv
/*
 * sstat_pkg: register map, field positions and widths for the spindle
 * status output bank.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`default_nettype none

package sstat_pkg;
   // register byte offsets
   localparam logic [7:0] SSTAT_FLAGS1_OFS = 8'h00;
   localparam logic [7:0] SSTAT_FLAGS2_OFS = 8'h04;
   localparam logic [7:0] SSTAT_SPEED_OFS = 8'h08;
   localparam logic [7:0] SSTAT_MISC_OFS = 8'h0c;
   localparam logic [7:0] SSTAT_SCODE_OFS = 8'h10;
   localparam logic [7:0] SSTAT_LOAD_OFS = 8'h14;
   localparam logic [7:0] SSTAT_FREQ_OFS = 8'h18;
   localparam logic [7:0] SSTAT_ALARM_OFS = 8'h1c;

   // spindle status byte field positions
   localparam int SSTAT_ALM_BIT = 0;
   localparam int SSTAT_HALT_BIT = 1;
   localparam int SSTAT_BELOW_BIT = 2;
   localparam int SSTAT_MATCH_BIT = 3;
   localparam int SSTAT_LOAD_BIT = 4;
   localparam int SSTAT_SPARE_BIT = 5;
   localparam int SSTAT_TORQUE_BIT = 6;
   localparam int SSTAT_ORIENT_BIT = 7;

   // misc word field positions
   localparam int SSTAT_MSTB_BIT = 0;
   localparam int SSTAT_SSTB_BIT = 1;
   localparam int SSTAT_NZV_BIT = 2;
   localparam int SSTAT_FLUCT_BIT = 3;
   localparam int SSTAT_CSS_BIT = 4;
   localparam int SSTAT_SPSY_BIT = 5;
   localparam int SSTAT_PHSY_BIT = 6;
   localparam int SSTAT_SYFLT_BIT = 7;
   localparam int SSTAT_RIGID_TAP_ACTIVE_BIT = 8;

   // value widths and ranges
   localparam int SSTAT_SPEED_W = 16;
   localparam logic [15:0] SSTAT_LOAD_MAX = 16'h7fff;
   localparam logic [15:0] SSTAT_FREQ_MAX = 16'h3fff;

   // reset values and bus responses
   localparam logic [31:0] SSTAT_ZERO_WORD = 32'h0000_0000;
   localparam logic [1:0] SSTAT_RESP_OKAY = 2'b00;
   localparam logic [1:0] SSTAT_RESP_SLVERR = 2'b10;
   localparam logic [1:0] SSTAT_RESP_DECERR = 2'b11;
endpackage

`default_nettype wire

// file: sstat_monitor.sv
/* sstat_mon: port checks on the spindle status bank.
   assumes one clock and binding from the bench top. */
`default_nettype none
module sstat_mon
   import sstat_pkg::*;
(
   // clock, reset, scan
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic scan_tick,
   // sources
   input wire logic [1:0] spindle_alarm,
   input wire logic [1:0] freq_below_stop,
   input wire logic [1:0] freq_not_above_preset,
   input wire logic [1:0] freq_in_range,
   input wire logic [1:0] load_over_level,
   input wire logic [1:0] torque_limit_on,
   input wire logic [1:0] orient_in_range,
   input wire logic [1:0] orient_commanded,
   input wire logic [15:0] speed_command_in,
   // outputs and read handshake
   input wire logic [7:0] first_spindle_status_flags,
   input wire logic [7:0] second_spindle_status_flags,
   input wire logic [15:0] speed_command_output,
   input wire logic nonzero_velocity_flag,
   input wire logic [15:0] load_meter_word,
   input wire logic [15:0] motor_frequency_word,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // expected flag byte per spindle, spare bit forced low
   function automatic logic [7:0] fl(int i);
      return {orient_commanded[i] & orient_in_range[i], torque_limit_on[i], 1'b0,
         load_over_level[i], freq_in_range[i], freq_not_above_preset[i],
         freq_below_stop[i], spindle_alarm[i]};
   endfunction
   logic [7:0] w1;
   logic [7:0] w2;
   // always_comb, not assign: the function reads the sources as globals, and a
   // continuous assign with constant arguments would never re-evaluate
   always_comb begin
      w1 = fl(0);
      w2 = fl(1);
   end
   alarm_bit_a: assert property (scan_tick |=> first_spindle_status_flags[0] == $past(spindle_alarm[0])) else $error("alarm bit wrong");
   first_byte_a: assert property (scan_tick |=> first_spindle_status_flags == $past(w1)) else $error("first flags wrong");
   second_byte_a: assert property (scan_tick |=> second_spindle_status_flags == $past(w2)) else $error("second flags wrong");
   spare_zero_a: assert property (!first_spindle_status_flags[5] && !second_spindle_status_flags[5]) else $error("spare bit set");
   nzv_flag_a: assert property (scan_tick |=> nonzero_velocity_flag == ($past(speed_command_in) != 16'h0000)) else $error("velocity flag wrong");
   speed_out_a: assert property (scan_tick |=> speed_command_output == $past(speed_command_in)) else $error("speed output wrong");
   load_range_a: assert property (load_meter_word <= SSTAT_LOAD_MAX) else $error("load out of range");
   freq_range_a: assert property (motor_frequency_word <= SSTAT_FREQ_MAX) else $error("freq out of range");
   scan_hold_a: assert property (!scan_tick |=> $stable(first_spindle_status_flags) && $stable(speed_command_output)) else $error("changed off scan");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   cover property (scan_tick && spindle_alarm[0]);
   cover property (s_axi_rvalid);
   cover property (scan_tick && speed_command_in != 16'h0000);
endmodule
`default_nettype wire

// file: sstat_scan.sv
/* sstat_scan: controller scan source, one-cycle pulse per request.
   assumes req is a one-cycle request on aclk from the bench. */
`default_nettype none
module sstat_scan (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request and scan pulse
   input wire logic req,
   output logic scan_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered so sources settle a cycle before the scan edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_tick <= 1'b0;
      end else begin
         scan_tick <= req;
      end
   end
endmodule
`default_nettype wire

// file: sstat_tb.sv
/* tb: register-level tests of the status bank over axi4-lite.
   assumes the scan partner and the bound port monitor. */
`default_nettype none
module tb;
   import sstat_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, req, scan_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, m_code_strobe, s_code_strobe, nonzero_velocity_flag;
   logic speed_fluctuation_alarm, constant_surface_speed_active, speed_sync_active;
   logic phase_sync_active, sync_fault_flag, rigid_tap_active;
   logic [7:0] first_spindle_status_flags, second_spindle_status_flags, alarm_number_byte;
   logic [7:0] s_axi_awaddr, s_axi_araddr, alarm_number_in, src1, src2, p;
   logic [15:0] speed_command_output, load_meter_word, motor_frequency_word;
   logic [15:0] speed_command_in, load_meter_in, motor_freq_in;
   logic [31:0] spindle_function_code, s_axi_rdata, s_axi_wdata, s_code_in, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [8:0] misc;
   int error_cnt, tests_run, cyc;
   // per-spindle sources: bit i of src1 spindle one, src2 spindle two
   wire logic [1:0] spindle_alarm = {src2[0], src1[0]};
   wire logic [1:0] freq_below_stop = {src2[1], src1[1]};
   wire logic [1:0] freq_not_above_preset = {src2[2], src1[2]};
   wire logic [1:0] freq_in_range = {src2[3], src1[3]};
   wire logic [1:0] load_over_level = {src2[4], src1[4]};
   wire logic [1:0] orient_commanded = {src2[5], src1[5]};
   wire logic [1:0] torque_limit_on = {src2[6], src1[6]};
   wire logic [1:0] orient_in_range = {src2[7], src1[7]};
   wire logic m_code_effective = misc[0];
   wire logic s_code_effective = misc[1];
   wire logic speed_out_of_range = misc[3];
   wire logic css_control_on = misc[4];
   wire logic speed_sync_on = misc[5];
   wire logic phase_sync_on = misc[6];
   wire logic sync_fault = misc[7];
   wire logic rigid_tap_on = misc[8];
   sstat_bank u_sstat_bank (.*);
   sstat_scan u_sstat_scan (.aclk(aclk), .aresetn(aresetn), .req(req), .scan_tick(scan_tick));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end
   function automatic logic [31:0] fx(logic [7:0] v);
      return {24'h0, v[7] & v[5], v[6], 1'b0, v[4:0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(n, d, e);
      chk("rresp", {30'h0, r}, {30'h0, SSTAT_RESP_OKAY});
   endtask
   task automatic wr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'hffff_ffff;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic scan();
      @(posedge aclk);
      req <= 1'b1;
      @(posedge aclk);
      req <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {aresetn, req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src1, src2, misc} = '0;
      {speed_command_in, load_meter_in, motor_freq_in, s_code_in, alarm_number_in} = '0;
      {error_cnt, tests_run, cyc} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // walking ones then mixes; second spindle sees the inverse
      for (int k = 0; k < 10; k++) begin
         p = (k < 8) ? 8'h01 << k : ((k == 8) ? 8'ha0 : 8'hff);
         src1 <= p;
         src2 <= ~p;
         scan();
         rc("flags1", SSTAT_FLAGS1_OFS, fx(p));
         rc("flags2", SSTAT_FLAGS2_OFS, fx(~p));
      end
      $display("flag bytes done");
      // one misc flag at a time; bit 2 comes from the speed command
      for (int k = 0; k < 9; k++) begin
         misc <= 9'h001 << k;
         speed_command_in <= (k == 2) ? 16'h8001 : 16'h0000;
         scan();
         rc("misc", SSTAT_MISC_OFS, {23'h0, 9'h001 << k});
         rc("speed", SSTAT_SPEED_OFS, (k == 2) ? 32'h8001 : 32'h0);
      end
      $display("misc word done");
      // overrange then exact full scale
      for (int j = 0; j < 2; j++) begin
         load_meter_in <= j ? SSTAT_LOAD_MAX : 16'hffff;
         motor_freq_in <= j ? SSTAT_FREQ_MAX : 16'h4000;
         s_code_in <= j ? 32'h8765_4321 : 32'h0123_abcd;
         alarm_number_in <= j ? 8'ha5 : 8'h5a;
         scan();
         rc("load", SSTAT_LOAD_OFS, {16'h0, SSTAT_LOAD_MAX});
         rc("freq", SSTAT_FREQ_OFS, {16'h0, SSTAT_FREQ_MAX});
         rc("scode", SSTAT_SCODE_OFS, j ? 32'h8765_4321 : 32'h0123_abcd);
         rc("alarm", SSTAT_ALARM_OFS, j ? 32'ha5 : 32'h5a);
      end
      $display("value words done");
      // sources move without a scan: reads must keep the old snapshot
      src1 <= 8'h00;
      s_code_in <= 32'h0;
      load_meter_in <= 16'h0000;
      repeat (3) @(posedge aclk);
      rc("hold_flags", SSTAT_FLAGS1_OFS, fx(8'hff));
      rc("hold_scode", SSTAT_SCODE_OFS, 32'h8765_4321);
      scan();
      rc("load_zero", SSTAT_LOAD_OFS, 32'h0);
      $display("snapshot done");
      // writes refused, nothing changes; unmapped place decodes out
      wr(SSTAT_FLAGS1_OFS);
      chk("bresp", {30'h0, r}, {30'h0, SSTAT_RESP_SLVERR});
      rc("after_wr", SSTAT_FLAGS1_OFS, 32'h0);
      wr(8'h40);
      chk("bresp_un", {30'h0, r}, {30'h0, SSTAT_RESP_DECERR});
      rd(8'h40);
      chk("rdata_un", d, 32'h0);
      chk("rresp_un", {30'h0, r}, {30'h0, SSTAT_RESP_DECERR});
      $display("bus refusals done");
      close_out();
   end
endmodule
bind sstat_bank sstat_mon u_sstat_mon (.*);
`default_nettype wire
